// File: bench/spi_register_access_slave_tb.sv
// Self-checking bench for the SPI register access slave
`timescale 1ns/1ps
`default_nettype none
module spi_register_access_slave_tb;
  import sra_pkg::*;

  // ==========
  // Signals
  // ==========
  logic ref_clk = 1'b0;
  logic arst_n;
  logic interface_select_pin;
  logic crc_en;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [5:0] rd_addr;
  logic [15:0] rd_data;
  logic crc_err;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_wr = 0;
  int n_err = 0;

  always #4 ref_clk = ~ref_clk;

  // Register file stand-in, distinct content per address
  function automatic logic [15:0] regv(input logic [5:0] a);
    return {2'b10, a, 2'b01, ~a};
  endfunction : regv

  assign rd_data = regv(rd_addr);

  // High cycles counted, so a stuck pulse shows up as extra counts
  always @(posedge ref_clk) begin
    if (wr_en === 1'b1) n_wr++;
    if (crc_err === 1'b1) n_err++;
  end

  sra_spi_slave #(.CRC_POLY_P(CRC_POLY), .CRC_SEED_P(CRC_SEED)) DUT (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n),
    .interface_select_pin_i(interface_select_pin), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .spi_crc_check_enable_i(crc_en), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .crc_err_o(crc_err));

  sra_spi_master u_mst (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe));

  // ==========
  // Helpers
  // ==========
  function automatic logic [3:0] crc4(input logic [15:0] w);
    logic [3:0] c;
    logic fb;
    c = CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ w[i];
      c = {c[2:0], 1'b0};
      if (fb) c = c ^ CRC_POLY;
    end
    return c;
  endfunction : crc4

  function automatic logic [19:0] frm(input logic rw, input logic [5:0] a,
                                      input logic [7:0] d);
    logic [15:0] w;
    w = {1'b0, rw, a, d};
    return {w, crc4(w)};
  endfunction : frm

  task automatic check(input logic [19:0] seen, input logic [19:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic send(input logic [19:0] tx, input int n,
                      output logic [19:0] rx);
    @(posedge ref_clk);
    #1;
    u_mst.xfer(tx, n, rx);
  endtask : send

  // ==========
  // Scenarios
  // ==========
  task automatic t_write;
    logic [19:0] rx;
    int w0;
    check(20'({miso_oe, wr_en, crc_err, wr_addr, wr_data}), 20'h0_0000,
          "reset outputs");
    check(20'(rd_addr), 20'h0_0000, "reset read address");
    for (int k = 0; k < 2; k++) begin
      w0 = n_wr;
      send(frm(1'b1, 6'h14 + 6'(k), 8'hA5 ^ 8'(k)), 16, rx);
      check(20'(rx[15:0]), 20'h0_0000, "no read yet");
      check(20'(n_wr - w0), 20'h0_0001, "one write pulse");
      check(20'({wr_addr, wr_data}), 20'({6'h14 + 6'(k), 8'hA5 ^ 8'(k)}),
            "write fields");
      check(20'(miso_oe), 20'h0_0000, "miso released");
    end
    $display("test write done");
  endtask : t_write

  task automatic t_read;
    logic [19:0] rx;
    logic [15:0] v;
    int w0;
    w0 = n_wr;
    send(frm(1'b0, 6'h24, 8'h00), 16, rx);
    check(20'(rd_addr), 20'h0_0024, "read select");
    check(20'(n_wr - w0), 20'h0_0000, "read writes nothing");
    check(20'(rx[15:0]), 20'h0_0000, "first stage data");
    send(frm(1'b0, 6'h25, 8'h00), 20, rx);
    v = regv(6'h24);
    check(rx, {v, crc4(v)}, "even word and crc");
    v = regv(6'h25);
    send(frm(1'b1, 6'h02, 8'h3C), 16, rx);
    check(20'(rx[15:0]), 20'({8'h00, v[7:0]}), "odd byte");
    check(20'(wr_addr), 20'h0_0002, "write during read");
    $display("test read done");
  endtask : t_read

  task automatic t_crc;
    logic [19:0] rx;
    logic [19:0] f;
    int w0;
    int e0;
    @(posedge ref_clk);
    #1 crc_en = 1'b1;
    w0 = n_wr;
    e0 = n_err;
    f = frm(1'b1, 6'h30, 8'h5A);
    send(f ^ 20'h0_0001, 20, rx);
    check(20'(n_wr - w0), 20'h0_0000, "bad crc dropped");
    check(20'(n_err - e0), 20'h0_0001, "crc error pulse");
    send(f, 20, rx);
    check(20'({wr_addr, wr_data}), 20'({6'h30, 8'h5A}), "good crc");
    send(frm(1'b1, 6'h31, 8'h66), 16, rx);
    check(20'(wr_addr), 20'h0_0031, "short frame checked on");
    @(posedge ref_clk);
    #1 crc_en = 1'b0;
    e0 = n_err;
    send(frm(1'b1, 6'h32, 8'h77) ^ 20'h0_0001, 20, rx);
    check(20'(wr_addr), 20'h0_0032, "crc ignored");
    check(20'(n_err - e0), 20'h0_0000, "no error when off");
    $display("test crc done");
  endtask : t_crc

  task automatic t_refuse;
    logic [19:0] rx;
    int w0;
    w0 = n_wr;
    send(frm(1'b1, 6'h08, 8'h11), 15, rx);
    send(frm(1'b1, 6'h09, 8'h22) | 20'h8_0000, 16, rx);
    check(20'(n_wr - w0), 20'h0_0000, "short or unsynced");
    @(posedge ref_clk);
    #1 interface_select_pin = 1'b0;
    repeat (4) @(posedge ref_clk);
    send(frm(1'b1, 6'h0A, 8'h33), 16, rx);
    check(20'(n_wr - w0), 20'h0_0000, "deselected write");
    check(20'(u_mst.oe_seen), 20'h0_0000, "miso not driven");
    @(posedge ref_clk);
    #1 interface_select_pin = 1'b1;
    repeat (4) @(posedge ref_clk);
    send(frm(1'b1, 6'h0B, 8'h44), 16, rx);
    check(20'(wr_addr), 20'h0_000B, "reselected write");
    w0 = n_wr;
    fork
      send(frm(1'b1, 6'h0C, 8'h55), 16, rx);
      begin
        repeat (40) @(posedge ref_clk);
        #1 interface_select_pin = 1'b0;
      end
    join
    check(20'(n_wr - w0), 20'h0_0000, "frame cut by deselect");
    check(20'(miso_oe), 20'h0_0000, "miso released on deselect");
    @(posedge ref_clk);
    #1 interface_select_pin = 1'b1;
    repeat (4) @(posedge ref_clk);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_reset;
    logic [19:0] rx;
    @(posedge ref_clk);
    #1 arst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    check(20'({rd_addr, miso_oe}), 20'h0_0000, "reset mid run");
    send(frm(1'b1, 6'h15, 8'h99), 16, rx);
    check(20'(rx[15:0]), 20'h0_0000, "no read after reset");
    check(20'({wr_addr, wr_data}), 20'({6'h15, 8'h99}),
          "write after reset");
    $display("test reset done");
  endtask : t_reset

  // ==========
  // Run control
  // ==========
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  initial begin
    arst_n = 1'b0;
    interface_select_pin = 1'b1;
    crc_en = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    t_write();
    t_read();
    t_crc();
    t_refuse();
    t_reset();
    print_verdict();
  end

  initial begin
    #200000;
    n_mismatch++;
    $display("unexpected at %0t: run exceeded its time limit", $time);
    print_verdict();
  end
endmodule : spi_register_access_slave_tb
`default_nettype wire

// File: bench/sra_spi_master.sv
// Behavioural SPI mode 3 master driving the register access slave
`timescale 1ns/1ps
`default_nettype none
module sra_spi_master (
  // Serial lines toward the slave
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  // ==========
  // Line state
  // ==========
  logic last_miso;
  logic oe_seen;

  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    last_miso = 1'b0;
    oe_seen = 1'b0;
  end

  // ==========
  // One framed transfer, MSB first
  // ==========
  // Undriven MISO reads as the inverse of its last level, never a clean 0
  task automatic xfer(input logic [19:0] tx, input int n,
                      output logic [19:0] rx);
    rx = 20'h0_0000;
    oe_seen = 1'b0;
    cs_n_o = 1'b0;
    mosi_o = tx[19];
    #64;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      mosi_o = tx[19-i];
      #32;
      sclk_o = 1'b1;
      last_miso = miso_oe_i ? miso_i : ~last_miso;
      oe_seen = oe_seen | miso_oe_i;
      rx = {rx[18:0], last_miso};
      #32;
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #64;
  endtask : xfer
endmodule : sra_spi_master
`default_nettype wire

// File: hdl/sra_crc4.sv
// Combinational four-bit CRC over one sixteen-bit word, MSB first
`timescale 1ns/1ps
`default_nettype none
module sra_crc4 #(
  parameter logic [sra_pkg::CRC_W-1:0] POLY = sra_pkg::CRC_POLY,
  parameter logic [sra_pkg::CRC_W-1:0] SEED = sra_pkg::CRC_SEED
) (
  // Word in, check value out
  input wire logic [sra_pkg::WORD_W-1:0] word_i,
  output logic [sra_pkg::CRC_W-1:0] crc_o
);
  import sra_pkg::*;

  always_comb begin
    logic [CRC_W-1:0] c;
    logic fb;
    c = SEED;
    fb = 1'b0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      fb = c[CRC_W-1] ^ word_i[i];
      c = {c[CRC_W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    crc_o = c;
  end

endmodule : sra_crc4
`default_nettype wire

// File: hdl/sra_pkg.sv
// Shared constants for the SPI register access slave
package sra_pkg;

  // ==========================================================================
  // Frame geometry
  // ==========================================================================
  localparam int CNT_W = 5;
  localparam int WORD_W = 16;
  localparam int CRC_W = 4;
  localparam int ADDR_W = 6;
  localparam int BYTE_W = 8;
  localparam logic [CNT_W-1:0] DATA_CLKS = 5'h10;
  localparam logic [CNT_W-1:0] FULL_CLKS = 5'h14;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
  localparam logic [CNT_W-1:0] LAST_DATA_FALL = 5'h0F;

  // ==========================================================================
  // Command word fields
  // ==========================================================================
  localparam int SYNC_BIT = 15;
  localparam int RW_BIT = 14;
  localparam int ADDR_MSB = 13;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam int ODD_BIT = 0;

  // ==========================================================================
  // CRC defaults and reset values
  // ==========================================================================
  localparam logic [CRC_W-1:0] CRC_POLY = 4'h3;
  localparam logic [CRC_W-1:0] CRC_SEED = 4'hF;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  // Pin order {select, clock, chip select, data}; clock and chip select idle high
  localparam logic [3:0] PIN_RST = 4'h6;

  // ==========================================================================
  // Frame state
  // ==========================================================================
  typedef enum logic [0:0] {
    SRA_IDLE,
    SRA_FRAME
  } sra_state_t;

endpackage : sra_pkg

// File: hdl/sra_spi_slave.sv
// SPI mode 3 register access slave, oversampled by the reference clock
//
// Function
// - Full-duplex four-wire SPI in mode 3, one interface per die.
// - SPI is active only while the interface select pin is high.
// - Pure slave; master drives clock, MOSI and select, up to 10 MHz.
// - From the seventeenth clock, a four-bit CRC follows the data on MISO.
// - Received CRC bits ignored unless the CRC check enable is set.
// - With checking on, a bad-CRC frame is dropped and CRC error flagged.
// - MOSI is sampled on rising serial clock edges.
// - The received frame is acted on only when chip select rises.
// - MISO carries data of the last read address, zeros if none yet.
// - A read takes two frames: select address, then data returns.
// - MISO changes on falling serial clock edges.
// - Even address returns the whole word; odd returns low byte only.
`timescale 1ns/1ps
`default_nettype none
module sra_spi_slave #(
  parameter logic [sra_pkg::CRC_W-1:0] CRC_POLY_P = sra_pkg::CRC_POLY,
  parameter logic [sra_pkg::CRC_W-1:0] CRC_SEED_P = sra_pkg::CRC_SEED
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Serial pins
  input wire logic interface_select_pin_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Configuration
  input wire logic spi_crc_check_enable_i,
  // Register file write side
  output logic wr_en_o,
  output logic [sra_pkg::ADDR_W-1:0] wr_addr_o,
  output logic [sra_pkg::BYTE_W-1:0] wr_data_o,
  // Register file read side
  output logic [sra_pkg::ADDR_W-1:0] rd_addr_o,
  input wire logic [sra_pkg::WORD_W-1:0] rd_data_i,
  // Error flag set pulse
  output logic crc_err_o
);
  import sra_pkg::*;

  // ==========================================================================
  // Pin synchronisation and edge detection
  // ==========================================================================
  logic interface_select_pin_s, sclk_s, cs_n_s, mosi_s;
  logic sclk_q, cs_n_q;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  // Clock and chip select idle high in mode 3, so they reset high
  sra_sync #(
    .WIDTH(4),
    .RESET_VAL(PIN_RST)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({interface_select_pin_i, sclk_i, cs_n_i, mosi_i}),
    .sync_o({interface_select_pin_s, sclk_s, cs_n_s, mosi_s})
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
    end
  end

  // Serial clock is only meaningful while selected
  assign sclk_rise = sclk_s & ~sclk_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_q & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_n_q;
  assign cs_rise = cs_n_s & ~cs_n_q;

  // ==========================================================================
  // CRC generation and checking
  // ==========================================================================
  logic [WORD_W-1:0] tx_word, rx_word;
  logic [CRC_W-1:0] rx_crc, tx_crc_calc, rx_crc_calc;

  sra_crc4 #(.POLY(CRC_POLY_P), .SEED(CRC_SEED_P)) u_crc_tx (
    .word_i(tx_word),
    .crc_o(tx_crc_calc)
  );

  sra_crc4 #(.POLY(CRC_POLY_P), .SEED(CRC_SEED_P)) u_crc_rx (
    .word_i(rx_word),
    .crc_o(rx_crc_calc)
  );

  // Saturating increment, shared by both bit counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
  endfunction : sat_inc

  // ==========================================================================
  // Frame state
  // ==========================================================================
  sra_state_t state, next_state;
  logic [CNT_W-1:0] rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
  logic [WORD_W-1:0] next_rx_word, tx_sh, next_tx_sh, next_tx_word;
  logic [CRC_W-1:0] next_rx_crc;
  logic rd_valid, next_rd_valid, next_miso, next_miso_oe, next_wr_en;
  logic [ADDR_W-1:0] next_rd_addr, next_wr_addr;
  logic [BYTE_W-1:0] next_wr_data;
  logic next_crc_err, crc_present, crc_bad, frame_ok;

  // A frame without its CRC nibble is taken as plain 16-bit
  assign crc_present = (rx_cnt >= FULL_CLKS);
  assign crc_bad = spi_crc_check_enable_i & crc_present
                   & (rx_crc != rx_crc_calc);
  assign frame_ok = (rx_cnt >= DATA_CLKS) & ~rx_word[SYNC_BIT];

  always_comb begin
    next_state = state;
    next_rx_cnt = rx_cnt;
    next_tx_cnt = tx_cnt;
    next_rx_word = rx_word;
    next_rx_crc = rx_crc;
    next_tx_sh = tx_sh;
    next_tx_word = tx_word;
    next_rd_valid = rd_valid;
    next_rd_addr = rd_addr_o;
    next_miso = miso_o;
    next_miso_oe = miso_oe_o;
    next_wr_en = 1'b0;
    next_wr_addr = wr_addr_o;
    next_wr_data = wr_data_o;
    next_crc_err = 1'b0;
    case (state)
      SRA_IDLE: begin
        next_miso_oe = 1'b0;
        if (interface_select_pin_s && cs_fall) begin
          next_state = SRA_FRAME;
          next_rx_cnt = CNT_ZERO;
          next_tx_cnt = CNT_ZERO;
          // Return data of the address chosen by the last read
          if (!rd_valid) begin
            next_tx_word = WORD_ZERO;
          end else if (rd_addr_o[ODD_BIT]) begin
            next_tx_word = {BYTE_ZERO, rd_data_i[DATA_MSB:DATA_LSB]};
          end else begin
            next_tx_word = rd_data_i;
          end
          next_tx_sh = next_tx_word;
          next_miso = next_tx_word[WORD_W-1];
          next_miso_oe = 1'b1;
        end
      end
      SRA_FRAME: begin
        if (!interface_select_pin_s) begin
          // Pins handed back to the other protocol mid-frame: drop it
          next_state = SRA_IDLE;
          next_miso_oe = 1'b0;
        end else if (cs_rise) begin
          next_state = SRA_IDLE;
          next_miso_oe = 1'b0;
          if (frame_ok && crc_bad) begin
            next_crc_err = 1'b1;
          end else if (frame_ok && rx_word[RW_BIT]) begin
            next_wr_en = 1'b1;
            next_wr_addr = rx_word[ADDR_MSB:ADDR_LSB];
            next_wr_data = rx_word[DATA_MSB:DATA_LSB];
          end else if (frame_ok) begin
            next_rd_valid = 1'b1;
            next_rd_addr = rx_word[ADDR_MSB:ADDR_LSB];
          end
        end else begin
          if (sclk_rise) begin
            next_rx_cnt = sat_inc(rx_cnt);
            if (rx_cnt < DATA_CLKS) begin
              next_rx_word = {rx_word[WORD_W-2:0], mosi_s};
            end else if (rx_cnt < FULL_CLKS) begin
              next_rx_crc = {rx_crc[CRC_W-2:0], mosi_s};
            end
          end
          if (sclk_fall) begin
            next_tx_cnt = sat_inc(tx_cnt);
            next_miso = tx_sh[WORD_W-1];
            if (tx_cnt == LAST_DATA_FALL) begin
              next_tx_sh = {tx_crc_calc, {(WORD_W-CRC_W){1'b0}}};
            end else begin
              next_tx_sh = {tx_sh[WORD_W-2:0], 1'b0};
            end
          end
        end
      end
      default: begin
        next_state = SRA_IDLE;
        next_miso_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= SRA_IDLE;
      rx_cnt <= CNT_ZERO;
      tx_cnt <= CNT_ZERO;
      rx_word <= WORD_ZERO;
      rx_crc <= '0;
      tx_sh <= WORD_ZERO;
      tx_word <= WORD_ZERO;
      rd_valid <= 1'b0;
      rd_addr_o <= ADDR_ZERO;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
      wr_en_o <= 1'b0;
      wr_addr_o <= ADDR_ZERO;
      wr_data_o <= BYTE_ZERO;
      crc_err_o <= 1'b0;
    end else begin
      state <= next_state;
      rx_cnt <= next_rx_cnt;
      tx_cnt <= next_tx_cnt;
      rx_word <= next_rx_word;
      rx_crc <= next_rx_crc;
      tx_sh <= next_tx_sh;
      tx_word <= next_tx_word;
      rd_valid <= next_rd_valid;
      rd_addr_o <= next_rd_addr;
      miso_o <= next_miso;
      miso_oe_o <= next_miso_oe;
      wr_en_o <= next_wr_en;
      wr_addr_o <= next_wr_addr;
      wr_data_o <= next_wr_data;
      crc_err_o <= next_crc_err;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_interface_select_pin_off;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !interface_select_pin_s |=> !miso_oe_o;
  endproperty
  a_interface_select_pin_off: assert property (p_interface_select_pin_off)
    else $error("MISO driven while SPI not selected");

  property p_write_on_cs_rise;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_en_o |-> $past(cs_rise) && $past(state == SRA_FRAME)
      && wr_addr_o == $past(rx_word[ADDR_MSB:ADDR_LSB])
      && wr_data_o == $past(rx_word[DATA_MSB:DATA_LSB]);
  endproperty
  a_write_on_cs_rise: assert property (p_write_on_cs_rise)
    else $error("Write issued without a closing chip select edge");

  property p_short_ignored;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state == SRA_FRAME && interface_select_pin_s && cs_rise && rx_cnt < DATA_CLKS)
      |=> !wr_en_o && !crc_err_o && $stable(rd_addr_o);
  endproperty
  a_short_ignored: assert property (p_short_ignored)
    else $error("Short frame was acted upon");

  property p_crc_discard;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state == SRA_FRAME && interface_select_pin_s && cs_rise && frame_ok
      && spi_crc_check_enable_i && crc_present && rx_crc != rx_crc_calc)
      |=> crc_err_o && !wr_en_o && $stable(rd_addr_o);
  endproperty
  a_crc_discard: assert property (p_crc_discard)
    else $error("Bad CRC frame not discarded and flagged");

  property p_crc_check_off;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !spi_crc_check_enable_i |=> !crc_err_o;
  endproperty
  a_crc_check_off: assert property (p_crc_check_off)
    else $error("CRC error flagged while checking disabled");

  property p_miso_on_fall;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state == SRA_FRAME && !sclk_fall && !cs_fall) |=> $stable(miso_o);
  endproperty
  a_miso_on_fall: assert property (p_miso_on_fall)
    else $error("MISO changed away from a falling clock edge");

  property p_odd_read;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state == SRA_IDLE && interface_select_pin_s && cs_fall && rd_valid && rd_addr_o[ODD_BIT])
      |=> tx_word[WORD_W-1:BYTE_W] == BYTE_ZERO
      && tx_word[DATA_MSB:DATA_LSB] == $past(rd_data_i[DATA_MSB:DATA_LSB]);
  endproperty
  a_odd_read: assert property (p_odd_read)
    else $error("Odd byte read returned wrong word");

  property p_no_read_zero;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state == SRA_IDLE && interface_select_pin_s && cs_fall && !rd_valid)
      |=> tx_word == WORD_ZERO ##1 !miso_o;
  endproperty
  a_no_read_zero: assert property (p_no_read_zero)
    else $error("Data returned before any read command");

  property p_crc_out;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state == SRA_FRAME && interface_select_pin_s && !cs_rise && sclk_fall
      && tx_cnt == DATA_CLKS) |=> miso_o == tx_crc_calc[CRC_W-1];
  endproperty
  a_crc_out: assert property (p_crc_out)
    else $error("CRC nibble not shifted out after data");

  property p_mosi_sample;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state == SRA_FRAME && interface_select_pin_s && !cs_rise && sclk_rise
      && rx_cnt < DATA_CLKS) |=> rx_word[0] == $past(mosi_s);
  endproperty
  a_mosi_sample: assert property (p_mosi_sample)
    else $error("MOSI not captured on rising clock edge");

  c_write: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_en_o);
  c_read_select: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    state == SRA_FRAME && cs_rise && frame_ok && !rx_word[RW_BIT]);
  c_crc_err: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    crc_err_o);
  c_long_frame: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    state == SRA_FRAME && cs_rise && rx_cnt == FULL_CLKS);

endmodule : sra_spi_slave
`default_nettype wire

// File: hdl/sra_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sra_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Pins and synchronised levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule : sra_sync
`default_nettype wire
